// [uif_pkg.sv]
// Behaviour
// - Enable bit 4 allows sleep, resets to 0, writable only with enhanced mode set.
// - Enable bit 5 unmasks received Xoff interrupt, resets 0, needs enhanced mode.
// - Enable bits 6,7 unmask RTS and CTS rising edges under auto flow control.
// - Without enhanced mode, status bits 4,5 and enhanced control bits are ignored.
// - Status read returns only highest pending source; lower ones stay queued.
// - Seven priority codes in status bits 5..0, line status highest, flow lowest.
// - Status bit 0 low while pending, high when idle; wake-up reports idle code.
// - Status bits 7 and 6 both mirror the FIFO enable.
// - Line status interrupt raised by error bits 1..4, cleared by line status read.
// - Receive data interrupt at trigger level, clears once level drops below it.
// - Receive timeout after four characters plus twelve bits, cleared by data read.
// - Transmit ready on trigger or empty, cleared by status read or data write.
// - Modem interrupt raised by modem bits 0..3, cleared by modem status read.
// - Xon/Xoff clears on status read; special char also on next received char.
// - RTS and CTS change interrupts are cleared by a modem status read.
// - Wake-up interrupt on leaving sleep when enabled, cleared by status read.
// - FIFO control bit 0 enables FIFOs; other bits ignored unless it is set.
// - FIFO control bit 1 pulses receive FIFO reset then self-clears.
// - FIFO control bit 2 pulses transmit FIFO reset then self-clears.
// - Bits 5..4 pick transmit trigger 1,4,8,14; needs enhanced mode.
// - Bits 7..6 pick receive trigger 1,4,8,14; interrupt when count crosses it.
// - One shared trigger; the most recently written selection governs both sides.
// - Receive status and interrupt assert at trigger and clear below it together.
package uif_pkg;
  // Register offsets; the status and FIFO control share one address
  localparam logic [2:0] ADDR_IER = 3'h1;
  localparam logic [2:0] ADDR_ISR = 3'h2;
  localparam logic [2:0] ADDR_EFR = 3'h3;
  // Reset values
  localparam logic [7:0] IER_RST = 8'h00;
  localparam logic [7:0] EFR_RST = 8'h00;
  localparam logic [1:0] TRIG_RST = 2'h0;
  // Field positions
  localparam int EFR_ENH = 4;
  localparam int EFR_ARTS = 6;
  localparam int EFR_ACTS = 7;
  localparam int FCR_EN = 0;
  localparam int FCR_RXRST = 1;
  localparam int FCR_TXRST = 2;
  localparam int FCR_WAKE = 3;
  // Status codes, bits 5..0
  localparam logic [5:0] CODE_LSR = 6'h06;
  localparam logic [5:0] CODE_RXTO = 6'h0C;
  localparam logic [5:0] CODE_RXD = 6'h04;
  localparam logic [5:0] CODE_TX = 6'h02;
  localparam logic [5:0] CODE_MSR = 6'h00;
  localparam logic [5:0] CODE_XCH = 6'h10;
  localparam logic [5:0] CODE_FLOW = 6'h20;
  localparam logic [5:0] CODE_NONE = 6'h01;
  // Trigger table
  localparam logic [4:0] TRIG_L0 = 5'h01;
  localparam logic [4:0] TRIG_L1 = 5'h04;
  localparam logic [4:0] TRIG_L2 = 5'h08;
  localparam logic [4:0] TRIG_L3 = 5'h0E;
  // Timeout: characters plus bits
  localparam logic [6:0] TO_CHARS = 7'h04;
  localparam logic [6:0] TO_BITS = 7'h0C;
  // Reported source, one-hot
  typedef enum logic [7:0] {
    SRC_NONE = 8'h01,
    SRC_LSR = 8'h02,
    SRC_RXTO = 8'h04,
    SRC_RXD = 8'h08,
    SRC_TX = 8'h10,
    SRC_MSR = 8'h20,
    SRC_XCH = 8'h40,
    SRC_FLOW = 8'h80
  } uif_src_t;
endpackage

// [uif_ctrl.sv]
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
module uif_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register port
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Access events from neighbouring registers
  input wire logic lsr_read,
  input wire logic msr_read,
  input wire logic rhr_read,
  input wire logic thr_write,
  // Status from the serial side
  input wire logic [3:0] lsr_err,
  input wire logic [3:0] msr_delta,
  input wire logic [4:0] rx_level,
  input wire logic [4:0] tx_level,
  input wire logic bit_tick,
  input wire logic [3:0] char_bits,
  input wire logic rx_char,
  input wire logic xon_det,
  input wire logic xoff_det,
  input wire logic special_det,
  input wire logic rts_out,
  input wire logic cts_in,
  input wire logic wake_event,
  // Control outputs
  output logic irq,
  output logic sleep_allow,
  output logic fifo_en,
  output logic rx_fifo_reset,
  output logic tx_fifo_reset,
  output logic [4:0] trig_level,
  output logic auto_rts_en,
  output logic auto_cts_en
);
  logic [7:0] interrupt_enable_reg;
  logic [7:0] enhanced_feature_reg;
  logic wake_en;
  logic [1:0] trig_sel;
  logic [1:0] rx_sel_last;
  logic [1:0] tx_sel_last;
  logic enh;
  logic fcr_wr;
  logic isr_rd;
  logic [4:0] trig;
  logic lsr_any;
  logic msr_any;
  logic lsr_any_q, msr_any_q, rts_q, cts_q, tx_below_q, tx_empty_q, ier1_q, filled_past;
  logic lsr_flag, msr_flag, to_flag, tx_flag, xch_flag, spc_flag, flow_flag, wake_flag;
  logic [6:0] to_cnt;
  logic [6:0] to_limit;
  logic tx_below;
  logic tx_set;
  logic rx_hit;
  logic p_lsr, p_to, p_rxd, p_tx, p_msr, p_xch, p_flow, any_pend;
  uif_pkg::uif_src_t cur;
  logic [5:0] code;

  assign enh = enhanced_feature_reg[uif_pkg::EFR_ENH];
  assign fcr_wr = wr && (addr == uif_pkg::ADDR_ISR);
  assign isr_rd = rd && (addr == uif_pkg::ADDR_ISR);
  assign sleep_allow = interrupt_enable_reg[4];
  assign auto_rts_en = enhanced_feature_reg[uif_pkg::EFR_ARTS];
  assign auto_cts_en = enhanced_feature_reg[uif_pkg::EFR_ACTS];
  assign trig_level = trig;

  // Enable register; upper half locked without enhanced mode
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      interrupt_enable_reg <= uif_pkg::IER_RST;
    end else if (wr && addr == uif_pkg::ADDR_IER) begin
      interrupt_enable_reg[3:0] <= wdata[3:0];
      if (enh) begin
        interrupt_enable_reg[7:4] <= wdata[7:4];
      end
    end
  end

  // Enhanced feature register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      enhanced_feature_reg <= uif_pkg::EFR_RST;
    end else if (wr && addr == uif_pkg::ADDR_EFR) begin
      enhanced_feature_reg <= wdata;
    end
  end

  // FIFO control; bit 0 must be set for the rest to land
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fifo_en <= 1'b0;
      wake_en <= 1'b0;
      trig_sel <= uif_pkg::TRIG_RST;
      rx_sel_last <= uif_pkg::TRIG_RST;
      tx_sel_last <= uif_pkg::TRIG_RST;
    end else if (fcr_wr) begin
      fifo_en <= wdata[uif_pkg::FCR_EN];
      if (wdata[uif_pkg::FCR_EN]) begin
        rx_sel_last <= wdata[7:6];
        if (enh) begin
          wake_en <= wdata[uif_pkg::FCR_WAKE];
          tx_sel_last <= wdata[5:4];
        end
        // A changed field is the newer choice; receive wins a tie
        if (wdata[7:6] != rx_sel_last) begin
          trig_sel <= wdata[7:6];
        end else if (enh && wdata[5:4] != tx_sel_last) begin
          trig_sel <= wdata[5:4];
        end
      end
    end
  end

  // Self-clearing FIFO resets, one cycle each
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_fifo_reset <= 1'b0;
      tx_fifo_reset <= 1'b0;
    end else begin
      rx_fifo_reset <= fcr_wr && wdata[uif_pkg::FCR_EN] && wdata[uif_pkg::FCR_RXRST];
      tx_fifo_reset <= fcr_wr && wdata[uif_pkg::FCR_EN] && wdata[uif_pkg::FCR_TXRST];
    end
  end

  // Trigger lookup; without FIFOs a single character triggers
  always_comb begin
    trig = uif_pkg::TRIG_L0;
    if (fifo_en) begin
      unique case (trig_sel)
        2'h0: trig = uif_pkg::TRIG_L0;
        2'h1: trig = uif_pkg::TRIG_L1;
        2'h2: trig = uif_pkg::TRIG_L2;
        2'h3: trig = uif_pkg::TRIG_L3;
      endcase
    end
  end

  assign lsr_any = |lsr_err;
  assign msr_any = |msr_delta;
  assign rx_hit = rx_level >= trig;
  assign tx_below = tx_level < trig;
  // Fall below trigger, or empty after a reload that never passed it
  assign tx_set = (tx_below && !tx_below_q)
                  || (tx_level == 5'h00 && !tx_empty_q && !filled_past)
                  || (tx_level == 5'h00 && tx_below_q && tx_empty_q && interrupt_enable_reg[1] && !ier1_q);

  // Edge history for event sources
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lsr_any_q <= 1'b0;
      msr_any_q <= 1'b0;
      rts_q <= 1'b0;
      cts_q <= 1'b0;
      tx_below_q <= 1'b1;
      tx_empty_q <= 1'b1;
      ier1_q <= 1'b0;
      filled_past <= 1'b0;
    end else begin
      lsr_any_q <= lsr_any;
      msr_any_q <= msr_any;
      rts_q <= rts_out;
      cts_q <= cts_in;
      tx_below_q <= tx_below;
      tx_empty_q <= tx_level == 5'h00;
      ier1_q <= interrupt_enable_reg[1];
      if (!tx_below) begin
        filled_past <= 1'b1;
      end else if (tx_level == 5'h00) begin
        filled_past <= 1'b0;
      end
    end
  end

  // Timeout in bit times; restarts on any receive activity
  assign to_limit = 7'(TO_MUL(char_bits)) + uif_pkg::TO_BITS;
  function automatic logic [6:0] TO_MUL(input logic [3:0] bits);
    TO_MUL = 7'({3'h0, bits} * uif_pkg::TO_CHARS);
  endfunction

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      to_cnt <= 7'h00;
    end else if (rx_char || rhr_read || rx_level == 5'h00) begin
      to_cnt <= 7'h00;
    end else if (bit_tick && to_cnt != to_limit) begin
      to_cnt <= to_cnt + 7'h01;
    end
  end

  // Sticky sources; a new event beats a same-cycle clear, except the timeout, where a same-cycle data read wins
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lsr_flag <= 1'b0;
      msr_flag <= 1'b0;
      to_flag <= 1'b0;
      tx_flag <= 1'b0;
    end else begin
      lsr_flag <= (lsr_any && !lsr_any_q) || (lsr_flag && !lsr_read);
      msr_flag <= (msr_any && !msr_any_q) || (msr_flag && !msr_read);
      to_flag <= (bit_tick && to_cnt == to_limit - 7'h01 && !rx_char && !rhr_read && rx_level != 5'h00)
                 || (to_flag && !rhr_read);
      tx_flag <= tx_set || (tx_flag && !thr_write && !(isr_rd && cur == uif_pkg::SRC_TX));
    end
  end

  // Enhanced sources, armed only in enhanced mode
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      xch_flag <= 1'b0;
      spc_flag <= 1'b0;
      flow_flag <= 1'b0;
      wake_flag <= 1'b0;
    end else begin
      xch_flag <= (enh && interrupt_enable_reg[5] && (xoff_det || xon_det))
                  || (xch_flag && !(isr_rd && cur == uif_pkg::SRC_XCH));
      spc_flag <= (enh && interrupt_enable_reg[5] && special_det)
                  || (spc_flag && !rx_char && !(isr_rd && cur == uif_pkg::SRC_XCH));
      flow_flag <= (enh && enhanced_feature_reg[uif_pkg::EFR_ARTS] && interrupt_enable_reg[6] && rts_out && !rts_q)
                   || (enh && enhanced_feature_reg[uif_pkg::EFR_ACTS] && interrupt_enable_reg[7] && cts_in && !cts_q)
                   || (flow_flag && !msr_read);
      wake_flag <= (enh && wake_en && wake_event)
                   || (wake_flag && !(isr_rd && cur == uif_pkg::SRC_NONE));
    end
  end

  // Pending after masks; enhanced status ignored outside enhanced mode
  assign p_lsr = lsr_flag && interrupt_enable_reg[2];
  assign p_to = to_flag && interrupt_enable_reg[0];
  assign p_rxd = rx_hit && interrupt_enable_reg[0];
  assign p_tx = tx_flag && interrupt_enable_reg[1];
  assign p_msr = msr_flag && interrupt_enable_reg[3];
  assign p_xch = (xch_flag || spc_flag) && enh;
  assign p_flow = flow_flag && enh;
  assign any_pend = p_lsr || p_to || p_rxd || p_tx || p_msr || p_xch || p_flow;

  // Priority encoder; lower sources simply wait their turn
  always_comb begin
    if (p_lsr) begin
      cur = uif_pkg::SRC_LSR;
    end else if (p_to) begin
      cur = uif_pkg::SRC_RXTO;
    end else if (p_rxd) begin
      cur = uif_pkg::SRC_RXD;
    end else if (p_tx) begin
      cur = uif_pkg::SRC_TX;
    end else if (p_msr) begin
      cur = uif_pkg::SRC_MSR;
    end else if (p_xch) begin
      cur = uif_pkg::SRC_XCH;
    end else if (p_flow) begin
      cur = uif_pkg::SRC_FLOW;
    end else begin
      cur = uif_pkg::SRC_NONE;
    end
  end

  // Source to status code
  always_comb begin
    unique case (cur)
      uif_pkg::SRC_LSR: code = uif_pkg::CODE_LSR;
      uif_pkg::SRC_RXTO: code = uif_pkg::CODE_RXTO;
      uif_pkg::SRC_RXD: code = uif_pkg::CODE_RXD;
      uif_pkg::SRC_TX: code = uif_pkg::CODE_TX;
      uif_pkg::SRC_MSR: code = uif_pkg::CODE_MSR;
      uif_pkg::SRC_XCH: code = uif_pkg::CODE_XCH;
      uif_pkg::SRC_FLOW: code = uif_pkg::CODE_FLOW;
      uif_pkg::SRC_NONE: code = uif_pkg::CODE_NONE;
    endcase
  end

  // Read data valid only the cycle after the strobe
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (rd) begin
      unique case (addr)
        uif_pkg::ADDR_IER: rdata <= interrupt_enable_reg;
        uif_pkg::ADDR_ISR: rdata <= {fifo_en, fifo_en, code};
        uif_pkg::ADDR_EFR: rdata <= enhanced_feature_reg;
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // Interrupt line; wake-up drives it though it shows the idle code
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= any_pend || wake_flag;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_rx_reset_req;
    fcr_wr && wdata[0] && wdata[1];
  endsequence
  sequence s_one_pulse;
    rx_fifo_reset ##1 !rx_fifo_reset;
  endsequence

  property p_sleep_lock;
    wr && addr == uif_pkg::ADDR_IER && !enh |=> sleep_allow == $past(sleep_allow) && interrupt_enable_reg[5] == $past(interrupt_enable_reg[5]);
  endproperty
  a_sleep_lock: assert property (p_sleep_lock) else $error("sleep or xoff enable changed without enhanced");

  property p_flow_set;
    enh && enhanced_feature_reg[uif_pkg::EFR_ARTS] && interrupt_enable_reg[6] && $rose(rts_out) |=> flow_flag;
  endproperty
  a_flow_set: assert property (p_flow_set) else $error("rts rise did not raise flow interrupt");

  property p_enh_hidden;
    isr_rd && !enh |=> rdata[5:4] == 2'h0;
  endproperty
  a_enh_hidden: assert property (p_enh_hidden) else $error("enhanced status seen without enhanced");

  property p_lsr_top;
    isr_rd && p_lsr |=> rdata[5:0] == uif_pkg::CODE_LSR;
  endproperty
  a_lsr_top: assert property (p_lsr_top) else $error("line status not reported first");

  property p_idle_code;
    isr_rd && !any_pend |=> rdata[0] == 1'b1;
  endproperty
  a_idle_code: assert property (p_idle_code) else $error("idle code missing");

  property p_fifo_bits;
    isr_rd |=> rdata[7:6] == {2{$past(fifo_en)}};
  endproperty
  a_fifo_bits: assert property (p_fifo_bits) else $error("fifo status bits wrong");

  property p_lsr_raise;
    $rose(lsr_any) |=> lsr_flag;
  endproperty
  a_lsr_raise: assert property (p_lsr_raise) else $error("line status interrupt not raised");

  property p_to_clear;
    rhr_read |=> !to_flag;
  endproperty
  a_to_clear: assert property (p_to_clear) else $error("timeout not cleared by data read");

  property p_tx_clear;
    thr_write && !tx_set |=> !tx_flag;
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("transmit ready not cleared by write");

  property p_fcr_ignore;
    fcr_wr && !wdata[0] |=> !fifo_en && $stable(trig_sel) && $stable(wake_en);
  endproperty
  a_fcr_ignore: assert property (p_fcr_ignore) else $error("fifo control accepted without bit 0");

  property p_rx_reset;
    s_rx_reset_req |=> s_one_pulse;
  endproperty
  a_rx_reset: assert property (p_rx_reset) else $error("receive reset not a single pulse");

  property p_irq;
    any_pend |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt output missing");
endmodule

// [uif_host.sv]
`timescale 1ns/100ps
module uif_host (
  // Clock
  input wire logic core_clk,
  // Register port
  output logic [2:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata
);
  // Idle bus from time zero
  initial begin
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // One-cycle write; data inverted after so nothing leans on a stale value
  task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask
  // Data stand only in the cycle after the strobe, taken at its closing edge
  task automatic read_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    @(posedge core_clk);
    d = rdata;
  endtask
endmodule

// [uif_ctrl_bench.sv]
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module uif_ctrl_bench;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] addr;
  logic [7:0] wdata, rdata;
  logic wr, rd;
  logic lsr_read = 0, msr_read = 0, rhr_read = 0, thr_write = 0;
  logic [3:0] lsr_err = 4'h0, msr_delta = 4'h0, char_bits = 4'h8;
  logic [4:0] rx_level = 5'h00, tx_level = 5'h10, trig_level;
  logic bit_tick = 0, rx_char = 0, xon_det = 0, xoff_det = 0, special_det = 0;
  logic rts_out = 0, cts_in = 0, wake_event = 0;
  logic irq, sleep_allow, fifo_en, rx_fifo_reset, tx_fifo_reset, auto_rts_en, auto_cts_en;
  int err_total = 0;
  int tests_run = 0;
  int rx_pulses = 0;
  int tx_pulses = 0;
  logic [4:0] trig_tab [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};

  // 10 MHz clock
  always #50 core_clk = ~core_clk;

  // Count reset pulse cycles to prove they are single-cycle
  always @(posedge core_clk) begin
    if (rx_fifo_reset === 1'b1) rx_pulses++;
    if (tx_fifo_reset === 1'b1) tx_pulses++;
  end

  uif_host u_host (.core_clk(core_clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

  uif_ctrl u_uif_ctrl (.core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .lsr_read(lsr_read), .msr_read(msr_read), .rhr_read(rhr_read), .thr_write(thr_write),
    .lsr_err(lsr_err), .msr_delta(msr_delta), .rx_level(rx_level), .tx_level(tx_level),
    .bit_tick(bit_tick), .char_bits(char_bits), .rx_char(rx_char), .xon_det(xon_det),
    .xoff_det(xoff_det), .special_det(special_det), .rts_out(rts_out), .cts_in(cts_in),
    .wake_event(wake_event), .irq(irq), .sleep_allow(sleep_allow), .fifo_en(fifo_en),
    .rx_fifo_reset(rx_fifo_reset), .tx_fifo_reset(tx_fifo_reset), .trig_level(trig_level),
    .auto_rts_en(auto_rts_en), .auto_cts_en(auto_cts_en));

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wr_r(input logic [2:0] a, input logic [7:0] d);
    u_host.write_reg(a, d);
    // Let the register update settle before anyone looks at outputs
    @(posedge core_clk);
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.read_reg(a, d);
    `CHK(d, exp)
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Reset values and unmapped place
  task automatic t_reset();
    `CHK(trig_level, 5'h01)
    `CHK({irq, sleep_allow, fifo_en}, 3'b000)
    rd_chk(uif_pkg::ADDR_IER, 8'h00);
    rd_chk(uif_pkg::ADDR_ISR, 8'h01);
    rd_chk(3'h0, 8'h00);
    wr_r(3'h7, 8'hFF);
    rd_chk(uif_pkg::ADDR_EFR, 8'h00);
  endtask

  // Upper enables locked until enhanced mode is on
  task automatic t_enables();
    wr_r(uif_pkg::ADDR_IER, 8'hFF);
    rd_chk(uif_pkg::ADDR_IER, 8'h0F);
    `CHK(sleep_allow, 1'b0)
    wr_r(uif_pkg::ADDR_EFR, 8'h10);
    wr_r(uif_pkg::ADDR_IER, 8'hFF);
    rd_chk(uif_pkg::ADDR_IER, 8'hFF);
    `CHK(sleep_allow, 1'b1)
  endtask

  // FIFO enable and self-clearing resets; bit 0 set in each write that counts
  task automatic t_fifo();
    wr_r(uif_pkg::ADDR_ISR, 8'h01);
    rd_chk(uif_pkg::ADDR_ISR, 8'hC1);
    wr_r(uif_pkg::ADDR_ISR, 8'h07);
    idle(3);
    `CHK(rx_pulses, 1)
    `CHK(tx_pulses, 1)
    wr_r(uif_pkg::ADDR_ISR, 8'h06);
    idle(3);
    `CHK({rx_pulses[1:0], tx_pulses[1:0], fifo_en}, 5'b01010)
    rd_chk(uif_pkg::ADDR_ISR, 8'h01);
    wr_r(uif_pkg::ADDR_ISR, 8'h01);
  endtask

  // Shared trigger table: tx codes then rx codes, ending on 14
  task automatic t_trigger();
    logic [1:0] txc [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    logic [1:0] rxc [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
    for (int i = 0; i < 4; i++) begin
      wr_r(uif_pkg::ADDR_ISR, {2'h0, txc[i], 4'h1});
      `CHK(trig_level, trig_tab[txc[i]])
    end
    for (int i = 0; i < 4; i++) begin
      wr_r(uif_pkg::ADDR_ISR, {rxc[i], 6'h01});
      `CHK(trig_level, trig_tab[rxc[i]])
    end
  endtask

  // Five sources at once (line status, receive data, transmit, modem, Xon), serviced in priority order
  task automatic t_priority();
    @(posedge core_clk);
    lsr_err <= 4'h1;
    msr_delta <= 4'h1;
    rx_level <= 5'h0E;
    tx_level <= 5'h00;
    xon_det <= 1'b1;
    @(posedge core_clk);
    xon_det <= 1'b0;
    tx_level <= 5'h10;
    idle(3);
    `CHK(irq, 1'b1)
    rd_chk(uif_pkg::ADDR_ISR, 8'hC6);
    rd_chk(uif_pkg::ADDR_ISR, 8'hC6);
    @(posedge core_clk);
    lsr_read <= 1'b1;
    lsr_err <= 4'h0;
    @(posedge core_clk);
    lsr_read <= 1'b0;
    rd_chk(uif_pkg::ADDR_ISR, 8'hC4);
    @(posedge core_clk);
    rx_level <= 5'h0D;
    idle(3);
    rd_chk(uif_pkg::ADDR_ISR, 8'hC2);
    rd_chk(uif_pkg::ADDR_ISR, 8'hC0);
    @(posedge core_clk);
    msr_read <= 1'b1;
    msr_delta <= 4'h0;
    @(posedge core_clk);
    msr_read <= 1'b0;
    rd_chk(uif_pkg::ADDR_ISR, 8'hD0);
    rd_chk(uif_pkg::ADDR_ISR, 8'hC1);
    rx_level <= 5'h00;
    idle(2);
    `CHK(irq, 1'b0)
  endtask

  // Flow-control change under automatic RTS
  task automatic t_flow();
    wr_r(uif_pkg::ADDR_EFR, 8'h50);
    `CHK(auto_rts_en, 1'b1)
    rts_out <= 1'b1;
    idle(3);
    rd_chk(uif_pkg::ADDR_ISR, 8'hE0);
    @(posedge core_clk);
    msr_read <= 1'b1;
    @(posedge core_clk);
    msr_read <= 1'b0;
    rts_out <= 1'b0;
    rd_chk(uif_pkg::ADDR_ISR, 8'hC1);
  endtask

  // Receive timeout: 4 chars of 8 bits plus 12 bits = 44 ticks
  task automatic t_timeout();
    rx_level <= 5'h01;
    for (int i = 0; i < 50; i++) begin
      @(posedge core_clk);
      bit_tick <= 1'b1;
      @(posedge core_clk);
      bit_tick <= 1'b0;
      if (i == 39) `CHK(irq, 1'b0)
    end
    idle(3);
    rd_chk(uif_pkg::ADDR_ISR, 8'hCC);
    rhr_read <= 1'b1;
    rx_level <= 5'h00;
    @(posedge core_clk);
    rhr_read <= 1'b0;
    rd_chk(uif_pkg::ADDR_ISR, 8'hC1);
  endtask

  // Wake-up reports idle code; Xoff held off by its enable
  task automatic t_wake_xoff();
    wr_r(uif_pkg::ADDR_ISR, 8'hC9);
    wake_event <= 1'b1;
    @(posedge core_clk);
    wake_event <= 1'b0;
    idle(3);
    `CHK(irq, 1'b1)
    rd_chk(uif_pkg::ADDR_ISR, 8'hC1);
    idle(2);
    `CHK(irq, 1'b0)
    wr_r(uif_pkg::ADDR_IER, 8'hDF);
    xoff_det <= 1'b1;
    @(posedge core_clk);
    xoff_det <= 1'b0;
    idle(3);
    `CHK(irq, 1'b0)
    // Transmit level drops below trigger, then a data write clears it
    tx_level <= 5'h00;
    idle(3);
    `CHK(irq, 1'b1)
    thr_write <= 1'b1;
    tx_level <= 5'h10;
    @(posedge core_clk);
    thr_write <= 1'b0;
    idle(3);
    `CHK(irq, 1'b0)
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #(100 * 20000);
    err_total++;
    close_out();
  end

  initial begin
    idle(10);
    rstn <= 1'b1;
    t_reset();
    t_enables();
    t_fifo();
    t_trigger();
    t_priority();
    t_flow();
    t_timeout();
    t_wake_xoff();
    close_out();
  end
endmodule
